// [design/gtc_pkg.sv]
`default_nettype none
package gtc_pkg;
	localparam int GTC_WIDTH = 16;
	localparam int GTC_BYTE = 8;
	localparam int GTC_PRE_W = 2;
	localparam int GTC_INSTR_DIV = 4;
	localparam logic [1:0] GTC_DIV_LAST = 2'h3;
	localparam logic [15:0] GTC_COUNT_RESET = 16'h0000;
	localparam logic [15:0] GTC_COUNT_ONE = 16'h0001;
	localparam logic [1:0] GTC_SRC_INSTR = 2'h0;
	localparam logic [1:0] GTC_SRC_SYS = 2'h1;
	localparam logic [1:0] GTC_SRC_EXT = 2'h2;
	localparam logic [1:0] GTC_SRC_RSVD = 2'h3;
	localparam logic [1:0] GTC_GATE_PIN = 2'h0;
	localparam logic [1:0] GTC_GATE_CMP1 = 2'h1;
	localparam logic [1:0] GTC_GATE_CMP2 = 2'h2;

	typedef struct packed {
		logic timer_run_bit;
		logic gate_enable_bit;
		logic [1:0] count_source_select;
		logic crystal_driver_enable;
		logic ext_sync_bit;
		logic [1:0] prescale_sel;
		logic [1:0] gate_source_sel;
		logic gate_polarity;
	} gtc_ctrl_t;

	typedef struct packed {
		logic wr_high;
		logic wr_low;
		logic [7:0] wdata;
	} gtc_wr_t;

	typedef enum logic [1:0] {
		GTC_ARMED = 2'b00,
		GTC_SEEN_LOW = 2'b01
	} gtc_edge_state_t;
endpackage
`default_nettype wire

// [design/gtc_sync2.sv]
`default_nettype none
module gtc_sync2
	import gtc_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	// first stage is read only by the second
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
		end
	end

	assign sync_out = stage2;
endmodule
`default_nettype wire

// [design/gtc_prescaler.sv]
`default_nettype none
module gtc_prescaler
	import gtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic tick_in,
	input wire logic clear,
	input wire logic [GTC_PRE_W-1:0] ratio_sel,
	output logic tick_out
);
	logic [2:0] count;
	logic [2:0] next_count;
	logic [2:0] limit;

	// ratio 1:1, 1:2, 1:4, 1:8
	always_comb begin
		limit = 3'((4'h1 << ratio_sel) - 4'h1);
		next_count = count;
		tick_out = 1'b0;
		if (clear) begin
			next_count = 3'h0;
		end else if (tick_in) begin
			if (count >= limit) begin
				next_count = 3'h0;
				tick_out = 1'b1;
			end else begin
				next_count = count + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count <= 3'h0;
		end else begin
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// [design/gtc_timer.sv]
`default_nettype none
// Function
// - sixteen-bit up counter read and written as high and low bytes
// - writing either byte replaces that byte of the live count at once
// - internal source makes a timer that steps once per instruction cycle
// - internal source steps on instruction cycle multiples set by the prescaler
// - external source steps on rising edges only, through the prescaler, timer or counter use
// - run off means off; run on counts always or only when gated
// - source select: 00 instr, 01 system, 10 crystal or pin, 11 reserved
// - system-clock source adds four per instruction cycle
// - count clock gateable by gate pin or either comparator output
// - counter steps on pin rising edges, synchronised whichever way ext_sync_bit is set
// - a falling edge must precede first counted rise after enable or write
module gtc_timer
	import gtc_pkg::*;
#(
	parameter int WIDTH = GTC_WIDTH
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire gtc_ctrl_t ctrl,
	input wire gtc_wr_t count_wr,
	input wire logic overflow_clear,
	input wire logic external_count_input,
	input wire logic crystal_clock_in,
	input wire logic gate_input_pin,
	input wire logic first_comparator_output,
	input wire logic second_comparator_output,
	output logic [GTC_BYTE-1:0] count_high_byte,
	output logic [GTC_BYTE-1:0] count_low_byte,
	output logic overflow_flag,
	output logic gate_open,
	output logic counter_running
);
	logic [2:0] pins_sync;
	logic ext_sync;
	logic xtal_sync;
	logic gate_pin_sync;
	logic cmp1_sync;
	logic cmp2_sync;

	// all pins cross into sys_clk before any logic reads them
	gtc_sync2 #(.WIDTH(3)) u_pin_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in({external_count_input, crystal_clock_in, gate_input_pin}),
		.sync_out(pins_sync)
	);
	gtc_sync2 #(.WIDTH(2)) u_cmp_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in({first_comparator_output, second_comparator_output}),
		.sync_out({cmp1_sync, cmp2_sync})
	);
	assign ext_sync = pins_sync[2];
	assign xtal_sync = pins_sync[1];
	assign gate_pin_sync = pins_sync[0];

	logic [1:0] div_cnt;
	logic [1:0] next_div_cnt;
	logic instr_tick;

	// one-cycle instruction enable, system clock divided by four
	always_comb begin
		next_div_cnt = div_cnt + 2'h1;
		instr_tick = (div_cnt == GTC_DIV_LAST);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	logic ext_level;
	logic ext_prev;
	logic next_ext_prev;
	logic async_mode;
	logic run_en;
	logic gate_raw;

	// asynchronous option still samples here; only one clock domain exists
	assign async_mode = ~ctrl.ext_sync_bit;
	assign ext_level = (ctrl.crystal_driver_enable) ? xtal_sync : ext_sync;

	always_comb begin
		case (ctrl.gate_source_sel)
			GTC_GATE_PIN: gate_raw = gate_pin_sync;
			GTC_GATE_CMP1: gate_raw = cmp1_sync;
			GTC_GATE_CMP2: gate_raw = cmp2_sync;
			default: gate_raw = gate_pin_sync;
		endcase
		gate_open = gate_raw ^ ctrl.gate_polarity;
		run_en = ctrl.timer_run_bit & (~ctrl.gate_enable_bit | gate_open);
	end

	gtc_edge_state_t edge_state;
	gtc_edge_state_t next_edge_state;
	logic ext_rise;
	logic any_write;

	assign any_write = count_wr.wr_high | count_wr.wr_low;

	// arm on a falling edge, not a low level: enabling while low must not count
	always_comb begin
		next_ext_prev = ext_level;
		next_edge_state = edge_state;
		ext_rise = 1'b0;
		if (!ctrl.timer_run_bit || any_write) begin
			next_edge_state = GTC_ARMED;
		end else begin
			case (edge_state)
				GTC_ARMED: begin
					if (ext_prev && !ext_level) begin
						next_edge_state = GTC_SEEN_LOW;
					end
				end
				GTC_SEEN_LOW: begin
					ext_rise = ext_level & ~ext_prev;
				end
				default: next_edge_state = GTC_ARMED;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			edge_state <= GTC_ARMED;
			ext_prev <= 1'b0;
		end else begin
			edge_state <= next_edge_state;
			ext_prev <= next_ext_prev;
		end
	end

	logic src_tick;
	logic [WIDTH-1:0] step;
	logic pre_tick;

	always_comb begin
		src_tick = 1'b0;
		step = WIDTH'(GTC_COUNT_ONE);
		case (ctrl.count_source_select)
			GTC_SRC_INSTR: src_tick = instr_tick;
			GTC_SRC_SYS: begin
				src_tick = instr_tick;
				step = WIDTH'(GTC_INSTR_DIV);
			end
			GTC_SRC_EXT: src_tick = ext_rise;
			GTC_SRC_RSVD: src_tick = 1'b0;
			default: src_tick = 1'b0;
		endcase
	end

	gtc_prescaler u_pre (
		.sys_clk(sys_clk),
		.reset(reset),
		.tick_in(src_tick & run_en),
		.clear(any_write | ~ctrl.timer_run_bit),
		.ratio_sel(ctrl.prescale_sel),
		.tick_out(pre_tick)
	);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic [WIDTH:0] sum;
	logic next_overflow;

	always_comb begin
		sum = {1'b0, count} + {1'b0, step};
		next_count = count;
		next_overflow = overflow_flag;
		if (overflow_clear) begin
			next_overflow = 1'b0;
		end
		if (pre_tick) begin
			next_count = sum[WIDTH-1:0];
			if (sum[WIDTH]) begin
				next_overflow = 1'b1;
			end
		end
		if (count_wr.wr_high) begin
			next_count[WIDTH-1 -: GTC_BYTE] = count_wr.wdata;
		end
		if (count_wr.wr_low) begin
			next_count[GTC_BYTE-1:0] = count_wr.wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count <= WIDTH'(GTC_COUNT_RESET);
			overflow_flag <= 1'b0;
		end else begin
			count <= next_count;
			overflow_flag <= next_overflow;
		end
	end

	assign count_high_byte = count[WIDTH-1 -: GTC_BYTE];
	assign count_low_byte = count[GTC_BYTE-1:0];
	assign counter_running = run_en;

	logic unused_async;
	assign unused_async = async_mode;

	property p_wrap_sets_flag;
		@(posedge sys_clk) disable iff (reset)
		(pre_tick && sum[WIDTH] && !any_write)
		|=> (overflow_flag && count == $past(sum[WIDTH-1:0]));
	endproperty
	a_wrap_sets_flag: assert property (p_wrap_sets_flag)
		else $error("wrap did not set overflow");

	property p_hold_when_off;
		@(posedge sys_clk) disable iff (reset)
		(!ctrl.timer_run_bit && !any_write) |=> $stable(count);
	endproperty
	a_hold_when_off: assert property (p_hold_when_off)
		else $error("count moved while off");

	property p_gate_closed;
		@(posedge sys_clk) disable iff (reset)
		(ctrl.gate_enable_bit && !gate_open && !any_write) |=> $stable(count);
	endproperty
	a_gate_closed: assert property (p_gate_closed)
		else $error("counting with gate closed");

	property p_low_write;
		@(posedge sys_clk) disable iff (reset)
		(count_wr.wr_low && !count_wr.wr_high) |=> count_low_byte == $past(count_wr.wdata);
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("low byte write lost");

	property p_high_write;
		@(posedge sys_clk) disable iff (reset)
		count_wr.wr_high |=> count_high_byte == $past(count_wr.wdata);
	endproperty
	a_high_write: assert property (p_high_write)
		else $error("high byte write lost");

	property p_no_rise_armed;
		@(posedge sys_clk) disable iff (reset)
		(edge_state == GTC_ARMED) |-> !ext_rise;
	endproperty
	a_no_rise_armed: assert property (p_no_rise_armed)
		else $error("rise counted before falling edge");

	property p_instr_rate;
		@(posedge sys_clk) disable iff (reset)
		instr_tick |=> !instr_tick [*3] ##1 instr_tick;
	endproperty
	a_instr_rate: assert property (p_instr_rate)
		else $error("instruction enable not one in four");

	property p_reserved_src;
		@(posedge sys_clk) disable iff (reset)
		(ctrl.count_source_select == GTC_SRC_RSVD) |-> !src_tick;
	endproperty
	a_reserved_src: assert property (p_reserved_src)
		else $error("reserved source counted");

	property p_sys_step;
		@(posedge sys_clk) disable iff (reset)
		(pre_tick && !any_write && ctrl.count_source_select == GTC_SRC_SYS)
		|=> count == $past(count) + WIDTH'(GTC_INSTR_DIV);
	endproperty
	a_sys_step: assert property (p_sys_step)
		else $error("system source did not add four");

	property p_ovf_clear;
		@(posedge sys_clk) disable iff (reset)
		(overflow_clear && !(pre_tick && sum[WIDTH])) |=> !overflow_flag;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear)
		else $error("overflow clear ignored");

	property p_write_rearm;
		@(posedge sys_clk) disable iff (reset)
		any_write |=> (edge_state == GTC_ARMED);
	endproperty
	a_write_rearm: assert property (p_write_rearm)
		else $error("write did not rearm edge detector");

	property p_idle_hold;
		@(posedge sys_clk) disable iff (reset)
		(!pre_tick && !any_write) |=> $stable(count);
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("count moved without a tick");

	property p_ext_rise_step;
		@(posedge sys_clk) disable iff (reset)
		(ctrl.count_source_select == GTC_SRC_EXT && ext_rise && run_en && !any_write
		&& ctrl.prescale_sel == '0) |=> count == $past(count) + WIDTH'(GTC_COUNT_ONE);
	endproperty
	a_ext_rise_step: assert property (p_ext_rise_step)
		else $error("external rise not counted");
endmodule
`default_nettype wire

// [tb/gtc_ext_model.sv]
`default_nettype none
module gtc_ext_model (
	input wire logic sys_clk,
	output logic ext_pin,
	output logic xtal,
	output logic gate_pin,
	output logic cmp1,
	output logic cmp2
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin idles high so a counter enabled here has not yet seen a low
	initial begin
		ext_pin = 1'h1;
		xtal = 1'h0;
		gate_pin = 1'h0;
		cmp1 = 1'h0;
		cmp2 = 1'h0;
	end
	// crystal period shortened to 16 system clocks to keep the run short
	task automatic pulses(input bit on_xtal, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge sys_clk);
			#1;
			if (on_xtal) xtal = 1'h0;
			else ext_pin = 1'h0;
			repeat (8) @(posedge sys_clk);
			#1;
			if (on_xtal) xtal = 1'h1;
			else ext_pin = 1'h1;
		end
	endtask
	task automatic set_gate(input int sel, input logic v);
		case (sel)
			0: gate_pin = v;
			1: cmp1 = v;
			default: cmp2 = v;
		endcase
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
	$display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
	import gtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, reset, overflow_clear, of, go, run;
	gtc_ctrl_t ctrl;
	gtc_wr_t count_wr;
	wire logic ext, xtal, gpin, c1, c2;
	logic [7:0] hi, lo;
	int fails, samples_checked;

	gtc_timer i_dut (.sys_clk(sys_clk), .reset(reset), .ctrl(ctrl), .count_wr(count_wr),
		.overflow_clear(overflow_clear), .external_count_input(ext), .crystal_clock_in(xtal),
		.gate_input_pin(gpin), .first_comparator_output(c1), .second_comparator_output(c2),
		.count_high_byte(hi), .count_low_byte(lo), .overflow_flag(of), .gate_open(go),
		.counter_running(run));
	gtc_ext_model i_ext (.sys_clk(sys_clk), .ext_pin(ext), .xtal(xtal), .gate_pin(gpin),
		.cmp1(c1), .cmp2(c2));

	initial sys_clk = 1'h0;
	always #2 sys_clk = ~sys_clk;

	function automatic logic [15:0] cnt();
		return {hi, lo};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic h, input logic [7:0] d);
		count_wr = '{wr_high: h, wr_low: ~h, wdata: d};
		step(1);
		count_wr = '0;
		step(1);
	endtask
	// window lengths are multiples of the tick period so start phase drops out
	task automatic meas(input int cyc, input logic [15:0] e);
		logic [15:0] a;
		step(8);
		a = cnt();
		step(cyc);
		`CHK(16'(cnt() - a), e)
	endtask
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic t_write;
		wr(1'h1, 8'hA5);
		wr(1'h0, 8'h3C);
		`CHK(cnt(), 16'hA53C)
		wr(1'h1, 8'h5A);
		`CHK(cnt(), 16'h5A3C)
		$display("t_write done");
	endtask
	task automatic t_rates;
		ctrl.timer_run_bit = 1'h1;
		ctrl.count_source_select = GTC_SRC_INSTR;
		meas(40, 16'h000A);
		ctrl.prescale_sel = 2'h2;
		meas(160, 16'h000A);
		ctrl.prescale_sel = 2'h0;
		ctrl.count_source_select = GTC_SRC_SYS;
		meas(40, 16'h0028);
		ctrl.count_source_select = GTC_SRC_RSVD;
		meas(40, 16'h0000);
		$display("t_rates done");
	endtask
	task automatic t_ext;
		ctrl.count_source_select = GTC_SRC_EXT;
		ctrl.ext_sync_bit = 1'h1;
		wr(1'h1, 8'h00);
		wr(1'h0, 8'h00);
		step(20);
		`CHK(cnt(), 16'h0000)
		i_ext.pulses(1'b0, 5);
		step(6);
		`CHK(cnt(), 16'h0005)
		ctrl.crystal_driver_enable = 1'h1;
		wr(1'h0, 8'h00);
		i_ext.pulses(1'b0, 2);
		step(6);
		`CHK(cnt(), 16'h0000)
		i_ext.pulses(1'b1, 4);
		step(6);
		// crystal sat low at the write, so its first rise has no falling edge before it
		`CHK(cnt(), 16'h0003)
		$display("t_ext done");
	endtask
	task automatic t_gate;
		ctrl.count_source_select = GTC_SRC_SYS;
		ctrl.gate_enable_bit = 1'h1;
		ctrl.gate_source_sel = GTC_GATE_PIN;
		meas(40, 16'h0000);
		`CHK(go, 1'h0)
		`CHK(run, 1'h0)
		for (int g = 0; g < 3; g++) begin
			ctrl.gate_source_sel = 2'(g);
			i_ext.set_gate(g, 1'h1);
			meas(40, 16'h0028);
			`CHK(go, 1'h1)
			`CHK(run, 1'h1)
			i_ext.set_gate(g, 1'h0);
		end
		ctrl.gate_source_sel = GTC_GATE_PIN;
		ctrl.gate_polarity = 1'h1;
		meas(40, 16'h0028);
		ctrl.gate_polarity = 1'h0;
		ctrl.gate_enable_bit = 1'h0;
		meas(40, 16'h0028);
		ctrl.timer_run_bit = 1'h0;
		meas(40, 16'h0000);
		$display("t_gate done");
	endtask
	task automatic t_ovf;
		wr(1'h1, 8'hFF);
		wr(1'h0, 8'hFC);
		ctrl.timer_run_bit = 1'h1;
		step(8);
		ctrl.timer_run_bit = 1'h0;
		step(2);
		`CHK(of, 1'h1)
		`CHK(cnt(), 16'h0004)
		overflow_clear = 1'h1;
		step(1);
		overflow_clear = 1'h0;
		step(1);
		`CHK(of, 1'h0)
		$display("t_ovf done");
	endtask

	initial begin
		ctrl = '0;
		count_wr = '0;
		overflow_clear = 1'h0;
		reset = 1'h1;
		repeat (8) @(posedge sys_clk);
		#1;
		reset = 1'h0;
		step(1);
		`CHK(cnt(), 16'h0000)
		`CHK(of, 1'h0)
		t_write();
		t_rates();
		t_ext();
		t_gate();
		t_ovf();
		finish_test();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		finish_test();
	end
endmodule
`default_nettype wire
